/* rtl/bcs_defs.svh */
// offsets, field positions and timing counts of the command block sequencer
`ifndef BCS_DEFS_SVH
`define BCS_DEFS_SVH
// register byte offsets
`define BCS_REG_CTRL 8'h00
`define BCS_REG_STAT 8'h04
`define BCS_REG_CCB 8'h08
`define BCS_REG_PCR 8'h0c
`define BCS_REG_HPIE 8'h10
`define BCS_REG_SIE 8'h14
`define BCS_REG_FLAGS 8'h18
// control word bit positions
`define BCS_CW_MERR 15
`define BCS_CW_SKIP 14
`define BCS_CW_INTC 13
`define BCS_CW_POLL 12
`define BCS_CW_RETRY 11
`define BCS_CW_EOL 10
`define BCS_CW_RTRT 9
`define BCS_CW_MON 8
// block word offsets
`define BCS_BLK_CW 3'd1
`define BCS_BLK_CMD1 3'd2
`define BCS_BLK_CMD2 3'd3
`define BCS_BLK_DLP 3'd4
`define BCS_BLK_ST1 3'd5
`define BCS_BLK_ST2 3'd6
`define BCS_BLK_TAIL 3'd7
// status word busy and message error bits
`define BCS_SW_BUSY 3
`define BCS_SW_MERR 10
// timing
`define BCS_CLK_MHZ 125
`define BCS_TICK_NS 16000
`define BCS_GAP_NS 4000
`define BCS_TICK_CYC (`BCS_TICK_NS * `BCS_CLK_MHZ / 1000)
`define BCS_GAP_CYC (`BCS_GAP_NS * `BCS_CLK_MHZ / 1000)
`endif

/* rtl/bcs_pkg.sv */
// types of the command block sequencer
package bcs_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_RD_CW, S_RD_CMD1, S_RD_DLP, S_RD_CMD2, S_MSG, S_DATA, S_WR_ST, S_WR_CW, S_RD_TAIL, S_WAIT
  } bcs_state_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bcs_mem_req_t;
  typedef struct packed {
    logic start;
    logic rtrt;
    logic bus_b;
    logic [15:0] cmd1;
    logic [15:0] cmd2;
  } bcs_msg_req_t;
  typedef struct packed {
    logic st_valid;
    logic st_sel;
    logic [15:0] status;
    logic dat_valid;
    logic [15:0] data;
    logic dat_req;
    logic done;
    logic timeout;
    logic bc_err;
  } bcs_msg_rsp_t;
endpackage

/* rtl/bcs_sequencer.sv */
// bus controller command block sequencer with ahb-lite registers
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`include "bcs_defs.svh"
module bcs_sequencer import bcs_pkg::*; #(
  parameter int TICK_CYC = `BCS_TICK_CYC,
  parameter int GAP_CYC = `BCS_GAP_CYC
) (
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [7:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write
  input wire logic [2:0] hsize, // size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output bcs_mem_req_t mem_req, // memory request
  input wire logic mem_ack, // memory done
  input wire logic [15:0] mem_rdata, // memory read data
  output bcs_msg_req_t msg_req, // message start to bus engine
  input bcs_msg_rsp_t msg_rsp, // bus engine events
  output logic hp_irq, // high priority interrupt level
  output logic std_irq // standard interrupt level
);
  typedef struct packed {
    bcs_state_t st;
    logic run;
    logic [15:0] ccb;
    logic [15:0] pcr;
    logic hpie;
    logic [1:0] sie;
    logic [2:0] retry_max;
    logic retry_opp;
    logic [2:0] retry_cnt;
    logic bus_b;
    logic [15:0] cw;
    logic [15:0] cmd1;
    logic [15:0] cmd2;
    logic [15:0] dptr;
    logic [15:0] stat;
    logic st_sel;
    logic err;
    logic [7:0] dly;
    logic [15:0] tick;
    logic [15:0] gap;
    logic msg_end;
    logic done_seen;
    bcs_mem_req_t mem;
    bcs_msg_req_t msg;
    logic hp;
    logic std;
    logic poll_hit;
    logic aph;
    logic apw;
    logic [7:0] apa;
    logic [31:0] rd;
  } bcs_s_t;
  bcs_s_t q, d;

  // memory word address inside current block
  function automatic logic [15:0] blk(input logic [15:0] base, input logic [2:0] off);
    blk = base + {13'h0000, off};
  endfunction

  // retry condition of a received status word
  function automatic logic st_bad(input logic [15:0] s);
    st_bad = s[`BCS_SW_BUSY] | s[`BCS_SW_MERR];
  endfunction

  always_comb begin
    d = q;
    d.msg.start = 1'b0;
    d.mem.req = q.mem.req & ~mem_ack;
    // ahb data phase
    if (q.aph && q.apw) begin
      case (q.apa)
        `BCS_REG_CTRL: begin
          // more than four retries is clamped to four
          d.retry_max = hwdata[3:1] > 3'h4 ? 3'h4 : hwdata[3:1];
          d.retry_opp = hwdata[4];
          if (hwdata[0] && q.st == S_IDLE) begin
            d.run = 1'b1;
            d.st = S_RD_CW;
            d.err = 1'b0;
            d.retry_cnt = 3'h0;
            // end of list leaves these set; a new run must not inherit them
            d.msg_end = 1'b0;
            d.done_seen = 1'b0;
            d.bus_b = 1'b0;
          end
        end
        `BCS_REG_CCB: d.ccb = hwdata[15:0];
        `BCS_REG_PCR: d.pcr = hwdata[15:0];
        `BCS_REG_HPIE: d.hpie = hwdata[0];
        `BCS_REG_SIE: d.sie = hwdata[1:0];
        default: ;
      endcase
      // write-one clears of the flags
      if (q.apa == `BCS_REG_FLAGS) begin
        d.hp = q.hp & ~hwdata[0];
        d.std = q.std & ~hwdata[1];
        d.poll_hit = q.poll_hit & ~hwdata[2];
      end
    end
    d.aph = hsel & hready & htrans[1];
    d.apw = hwrite;
    d.apa = haddr;
    case (haddr)
      `BCS_REG_CTRL: d.rd = {27'h0, q.retry_opp, q.retry_max, 1'b0};
      `BCS_REG_STAT: d.rd = {27'h0, q.st == S_IDLE ? 1'b0 : 1'b1, 3'h0, q.run};
      `BCS_REG_CCB: d.rd = {16'h0, q.ccb};
      `BCS_REG_PCR: d.rd = {16'h0, q.pcr};
      `BCS_REG_HPIE: d.rd = {31'h0, q.hpie};
      `BCS_REG_SIE: d.rd = {30'h0, q.sie};
      `BCS_REG_FLAGS: d.rd = {29'h0, q.poll_hit, q.std, q.hp};
      default: d.rd = 32'h0;
    endcase
    // 16 us tick and delay countdown, minimum gap
    if (q.tick != 16'h0) d.tick = q.tick - 16'h1;
    else if (q.dly != 8'h0) begin
      d.dly = q.dly - 8'h1;
      d.tick = 16'(TICK_CYC - 1);
    end
    if (q.gap != 16'h0) d.gap = q.gap - 16'h1;
    // done may come while a status write is still pending, so keep it
    if (msg_rsp.done) d.done_seen = 1'b1;
    case (q.st)
      S_IDLE: ;
      S_RD_CW: begin
        if (!q.mem.req && !mem_ack) d.mem = '{req: 1'b1, we: 1'b0, addr: blk(q.ccb, `BCS_BLK_CW), wdata: 16'h0};
        if (mem_ack) begin
          d.cw = mem_rdata;
          d.st = S_RD_CMD1;
          if (mem_rdata[`BCS_CW_INTC] && q.sie[0] && q.retry_cnt == 3'h0) d.std = 1'b1;
        end
      end
      S_RD_CMD1: begin
        if (!q.mem.req && !mem_ack) d.mem = '{req: 1'b1, we: 1'b0, addr: blk(q.ccb, `BCS_BLK_CMD1), wdata: 16'h0};
        if (mem_ack) begin
          d.cmd1 = mem_rdata;
          d.st = S_RD_DLP;
        end
      end
      S_RD_DLP: begin
        if (!q.mem.req && !mem_ack) d.mem = '{req: 1'b1, we: 1'b0, addr: blk(q.ccb, `BCS_BLK_DLP), wdata: 16'h0};
        if (mem_ack) begin
          d.dptr = mem_rdata;
          d.st = q.cw[`BCS_CW_RTRT] ? S_RD_CMD2 : S_MSG;
        end
      end
      S_RD_CMD2: begin
        if (!q.mem.req && !mem_ack) d.mem = '{req: 1'b1, we: 1'b0, addr: blk(q.ccb, `BCS_BLK_CMD2), wdata: 16'h0};
        if (mem_ack) begin
          d.cmd2 = mem_rdata;
          d.st = S_MSG;
        end
      end
      S_MSG: begin
        // wait gap; then start and arm delay from message start
        if (q.gap == 16'h0 && !q.msg_end) begin
          d.msg_end = 1'b1;
          d.done_seen = 1'b0;
          if (q.retry_cnt == 3'h0) begin
            // zero field means no programmed delay; first tick is loaded here
            d.dly = q.cw[7:0] != 8'h0 ? q.cw[7:0] - 8'h1 : 8'h0;
            d.tick = q.cw[7:0] != 8'h0 ? 16'(TICK_CYC - 1) : 16'h0;
          end
          if (q.cw[`BCS_CW_SKIP]) d.st = S_WAIT;
          else begin
            d.msg = '{start: 1'b1, rtrt: q.cw[`BCS_CW_RTRT], bus_b: q.bus_b, cmd1: q.cmd1, cmd2: q.cmd2};
            d.st = S_DATA;
          end
        end
      end
      S_DATA: begin
        // data one word per transfer, incrementing address
        if (msg_rsp.dat_req && !q.mem.req) begin
          d.mem = '{req: 1'b1, we: 1'b0, addr: q.dptr, wdata: 16'h0};
          d.dptr = q.dptr + 16'h1;
        end
        if (msg_rsp.dat_valid && (!q.cw[`BCS_CW_RTRT] || q.cw[`BCS_CW_MON])) begin
          d.mem = '{req: 1'b1, we: 1'b1, addr: q.dptr, wdata: msg_rsp.data};
          d.dptr = q.dptr + 16'h1;
        end
        if (msg_rsp.st_valid) begin
          d.stat = msg_rsp.status;
          d.st_sel = msg_rsp.st_sel;
          d.st = S_WR_ST;
          // polling match of pattern and status
          if (q.cw[`BCS_CW_POLL] && (q.pcr & msg_rsp.status) != 16'h0) begin
            d.poll_hit = 1'b1;
            if (q.sie[1]) d.std = 1'b1;
          end
          if (st_bad(msg_rsp.status)) d.err = 1'b1;
        end
        if (msg_rsp.timeout || msg_rsp.bc_err) d.err = 1'b1;
        if ((msg_rsp.done || q.done_seen) && !msg_rsp.st_valid && !q.mem.req) begin
          d.done_seen = 1'b0;
          d.st = q.err ? S_WR_CW : S_RD_TAIL;
          d.gap = 16'(GAP_CYC);
        end
      end
      S_WR_ST: begin
        // status to sixth or seventh word
        if (!q.mem.req && !mem_ack) begin
          d.mem = '{req: 1'b1, we: 1'b1, addr: blk(q.ccb, q.st_sel ? `BCS_BLK_ST2 : `BCS_BLK_ST1), wdata: q.stat};
        end
        if (mem_ack) d.st = S_DATA;
      end
      S_WR_CW: begin
        // retry on same or opposite bus, up to the programmed count
        if (q.cw[`BCS_CW_RETRY] && q.retry_cnt < q.retry_max && q.retry_max != 3'h0) begin
          d.retry_cnt = q.retry_cnt + 3'h1;
          d.bus_b = q.retry_opp ? ~q.bus_b : q.bus_b;
          d.err = 1'b0;
          d.msg_end = 1'b0;
          d.st = S_RD_CW;
        end else begin
          // mark error in control word and move on
          if (!q.mem.req && !mem_ack) begin
            d.mem = '{req: 1'b1, we: 1'b1, addr: blk(q.ccb, `BCS_BLK_CW), wdata: q.cw | 16'h8000};
          end
          if (mem_ack) d.st = S_RD_TAIL;
        end
      end
      S_RD_TAIL: begin
        // end of list halts after the message
        if (q.cw[`BCS_CW_EOL]) begin
          d.run = 1'b0;
          d.st = S_IDLE;
          if (q.hpie) d.hp = 1'b1;
        end else begin
          if (!q.mem.req && !mem_ack) d.mem = '{req: 1'b1, we: 1'b0, addr: blk(q.ccb, `BCS_BLK_TAIL), wdata: 16'h0};
          if (mem_ack) begin
            // current block register takes next address
            d.ccb = mem_rdata;
            d.st = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        // wait remaining delay; none left if message overran
        if (q.dly == 8'h0 && q.tick == 16'h0) begin
          if (q.cw[`BCS_CW_SKIP]) begin
            // skipped block: tail read or end of list comes after the delay
            d.st = S_RD_TAIL;
            d.cw[`BCS_CW_SKIP] = 1'b0;
          end else begin
            d.st = S_RD_CW;
          end
          d.retry_cnt = 3'h0;
          d.err = 1'b0;
          d.msg_end = 1'b0;
          d.bus_b = 1'b0;
        end
      end
      default: d.st = S_IDLE;
    endcase
  end

  // all state in one register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops, hreadyout and hresp tied off; slave never waits
  assign hrdata = q.rd;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign mem_req = q.mem;
  assign msg_req = q.msg;
  assign hp_irq = q.hp;
  assign std_irq = q.std;

  a_no_head_access: assert property (@(posedge hclk) disable iff (!hresetn)
    q.mem.req && q.st != S_DATA |-> q.mem.addr != q.ccb) else $error("head pointer accessed");
  a_eol_halt: assert property (@(posedge hclk) disable iff (!hresetn)
    q.st == S_RD_TAIL && q.cw[`BCS_CW_EOL] |=> !q.run && q.st == S_IDLE) else $error("no halt at end of list");
  a_skip_no_msg: assert property (@(posedge hclk) disable iff (!hresetn)
    q.st == S_MSG && q.cw[`BCS_CW_SKIP] |=> !q.msg.start) else $error("message on skipped block");
  a_min_gap: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(q.msg.start) |-> $past(q.gap) == 16'h0) else $error("gap too short");
  a_poll_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    q.st == S_DATA && msg_rsp.st_valid && q.cw[`BCS_CW_POLL] && (q.pcr & msg_rsp.status) != 16'h0
    |=> q.poll_hit) else $error("poll match lost");
  a_retry_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    q.retry_cnt <= 3'h4) else $error("too many retries");
  // status lands in word six or seven
  a_status_slot: assert property (@(posedge hclk) disable iff (!hresetn)
    q.st == S_WR_ST && q.mem.req |-> q.mem.we && (q.mem.addr == q.ccb + 16'h5 || q.mem.addr == q.ccb + 16'h6))
    else $error("status misplaced");
  a_ccb_update: assert property (@(posedge hclk) disable iff (!hresetn)
    q.st == S_RD_TAIL && !q.cw[`BCS_CW_EOL] && mem_ack |=> q.ccb == $past(mem_rdata)) else $error("ccb stale");
endmodule

/* test/bcs_far.sv */
// host memory and bus engine model facing the command block sequencer
module bcs_far import bcs_pkg::*; (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input bcs_mem_req_t mem_req, // memory request
  output logic mem_ack, // memory done
  output logic [15:0] mem_rdata, // read data
  input bcs_msg_req_t msg_req, // message start
  output bcs_msg_rsp_t msg_rsp // engine events
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ram [256];
  logic [15:0] sw = 16'h0000; // status the terminal returns
  logic [15:0] c2; // second command seen
  logic bs [16]; // bus of each start
  logic rt;
  int ts [16]; // cycle of each start
  int lat = 0, n_start = 0, n_head = 0, gap_min = 1000, t_done = 0, cyc = 0;
  always @(posedge hclk) cyc <= cyc + 1;
  // one access at a time; released read data turns to its inverse
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 16'h0000;
    forever begin
      @(posedge hclk);
      if (hresetn && mem_req.req === 1'b1) begin
        repeat (lat) @(posedge hclk);
        if (mem_req.addr < 16'h0080 && mem_req.addr[2:0] == 3'd0) n_head++; // head words sit below 0x80
        if (mem_req.we) ram[mem_req.addr[7:0]] = mem_req.wdata;
        mem_rdata <= ram[mem_req.addr[7:0]];
        mem_ack <= 1'b1;
        @(posedge hclk);
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
      end
    end
  end
  // terminal: status, two data and second status when rtrt, then done
  initial begin
    msg_rsp = '0;
    forever begin
      @(posedge hclk);
      if (hresetn && msg_req.start === 1'b1) begin
        if (n_start > 0 && cyc - t_done < gap_min) gap_min = cyc - t_done;
        ts[n_start] = cyc;
        bs[n_start] = msg_req.bus_b;
        n_start++;
        rt = msg_req.rtrt;
        c2 = msg_req.cmd2;
        for (int i = 0; i < (rt ? 4 : 1); i++) begin
          repeat (6) @(posedge hclk);
          msg_rsp.st_valid <= (i == 0 || i == 3);
          msg_rsp.st_sel <= (i == 3);
          msg_rsp.status <= (i == 3) ? sw ^ 16'h0001 : sw;
          msg_rsp.dat_valid <= (i == 1 || i == 2);
          msg_rsp.data <= 16'h00a0 + 16'(i);
          @(posedge hclk);
          msg_rsp.st_valid <= 1'b0;
          msg_rsp.dat_valid <= 1'b0;
          msg_rsp.status <= ~msg_rsp.status;
          msg_rsp.data <= ~msg_rsp.data;
        end
        repeat (4) @(posedge hclk);
        msg_rsp.done <= 1'b1;
        @(posedge hclk);
        msg_rsp.done <= 1'b0;
        t_done = cyc;
      end
    end
  end
endmodule

/* test/tb_top.sv */
// self-checking bench for the command block sequencer
`include "bcs_defs.svh"
module tb_top import bcs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 20;
  localparam int GAP = 5;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic hreadyout, hresp, hp_irq, std_irq, mem_ack;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic [31:0] hwdata = 32'h0, hrdata, rd, fl;
  logic [15:0] mem_rdata;
  bcs_mem_req_t mem_req;
  bcs_msg_req_t msg_req;
  bcs_msg_rsp_t msg_rsp;
  int n_fail = 0, n_compared = 0, t0 = 0;
  bcs_sequencer #(.TICK_CYC(TICK), .GAP_CYC(GAP)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .msg_req(msg_req), .msg_rsp(msg_rsp), .hp_irq(hp_irq), .std_irq(std_irq));
  bcs_far i_far (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .msg_req(msg_req), .msg_rsp(msg_rsp));
  // 125 mhz clock
  initial forever #4 hclk = ~hclk;
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_ge(input int got, input int lo);
    n_compared++;
    if (got < lo) begin
      n_fail++;
      $display("BAD t=%0t got=%h min=%h", $time, got, lo);
    end
  endtask
  // bounded wait: n below zero waits for hp_irq, else for n starts
  task automatic wait_ev(input int n);
    int k;
    for (k = 0; k < 4000; k++) begin
      @(posedge hclk);
      if (n < 0 ? hp_irq === 1'b1 : i_far.n_start >= n) break;
    end
    if (k == 4000) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 16);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      summarize();
    end
  endtask
  // one single ahb-lite transfer; read data lands in rd
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask
  task automatic blk(input int b, input logic [15:0] cw, input logic [15:0] tail);
    i_far.ram[b] = 16'h5a5a;
    i_far.ram[b + 1] = cw;
    i_far.ram[b + 2] = 16'h0821;
    i_far.ram[b + 3] = 16'h0c22;
    i_far.ram[b + 4] = 16'h0080 + 16'(b);
    i_far.ram[b + 5] = 16'h0000;
    i_far.ram[b + 6] = 16'h0000;
    i_far.ram[b + 7] = tail;
  endtask
  task automatic go(input logic [31:0] base, input logic [31:0] ctrl);
    i_far.n_start = 0;
    i_far.gap_min = 1000;
    t0 = i_far.cyc;
    ahb(`BCS_REG_CCB, 1'b1, base);
    ahb(`BCS_REG_CTRL, 1'b1, ctrl);
  endtask
  // end of list: running bit low, hp flag up; flags kept in fl, then cleared
  task automatic fin();
    wait_ev(-1);
    ahb(`BCS_REG_STAT, 1'b0, 32'h0);
    chk(rd & 32'h1, 32'h0);
    ahb(`BCS_REG_FLAGS, 1'b0, 32'h0);
    fl = rd;
    chk(fl & 32'h1, 32'h1);
    ahb(`BCS_REG_FLAGS, 1'b1, 32'h7);
  endtask
  task automatic s_regs();
    ahb(`BCS_REG_STAT, 1'b0, 32'h0);
    chk(rd, 32'h0);
    ahb(8'h1c, 1'b0, 32'h0);
    chk(rd, 32'h0);
    chk(hresp, 1'b0);
    ahb(`BCS_REG_HPIE, 1'b1, 32'h1);
    ahb(`BCS_REG_CCB, 1'b1, 32'h48);
    ahb(`BCS_REG_CCB, 1'b0, 32'h0);
    chk(rd, 32'h48);
  endtask
  task automatic s_chain();
    blk(8'h00, 16'h0003, 16'h0008);
    blk(8'h08, 16'h0000, 16'h0010);
    blk(8'h10, 16'h0400, 16'h0000);
    i_far.sw = 16'h0800;
    go(32'h0, 32'h1);
    wait_ev(2);
    ahb(`BCS_REG_CCB, 1'b0, 32'h0);
    chk(rd, 32'h8);
    fin();
    chk(i_far.n_start, 3);
    chk_ge(i_far.ts[1] - i_far.ts[0], 3 * TICK);
    chk_ge(i_far.gap_min, GAP);
    chk(i_far.ram[8'h05], 16'h0800);
    chk(i_far.ram[8'h0d], 16'h0800);
  endtask
  task automatic s_skip();
    ahb(`BCS_REG_SIE, 1'b1, 32'h1);
    blk(8'h20, 16'h6002, 16'h0028);
    blk(8'h28, 16'h0400, 16'h0000);
    go(32'h20, 32'h1);
    fin();
    chk(i_far.n_start, 1);
    chk_ge(i_far.ts[0] - t0, 2 * TICK);
    chk((fl >> 1) & 32'h1, 32'h1);
  endtask
  task automatic s_retry();
    for (int r = 1; r <= 4; r++) begin
      blk(8'h30, 16'h0c00, 16'h0000);
      i_far.sw = r[0] ? 16'h0008 : 16'h0400;
      go(32'h30, 32'h11 | 32'(r << 1));
      fin();
      chk(i_far.n_start, r + 1);
      chk(i_far.bs[0] ^ i_far.bs[1], 1'b1);
      if (!r[0]) chk(i_far.ram[8'h31] & 16'h8000, 16'h8000);
    end
  endtask
  task automatic s_poll();
    ahb(`BCS_REG_PCR, 1'b1, 32'h10);
    ahb(`BCS_REG_SIE, 1'b1, 32'h3);
    for (int m = 0; m < 2; m++) begin
      blk(8'h38, 16'h1400, 16'h0000);
      i_far.sw = m ? 16'h0030 : 16'h0021;
      go(32'h38, 32'h1);
      fin();
      chk((fl >> 2) & 32'h1, m);
    end
  endtask
  task automatic s_rtrt();
    i_far.lat = 3;
    blk(8'h40, 16'h0700, 16'h0000);
    i_far.sw = 16'h0800;
    go(32'h40, 32'h1);
    fin();
    chk(i_far.c2, 16'h0c22);
    chk(i_far.ram[8'hc0], 16'h00a1);
    chk(i_far.ram[8'hc1], 16'h00a2);
    chk(i_far.ram[8'h45], 16'h0800);
    chk(i_far.ram[8'h46], 16'h0801);
  endtask
  // reset for 20 cycles, then each scenario in turn
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_regs();
    s_chain();
    s_skip();
    s_retry();
    s_poll();
    s_rtrt();
    chk(i_far.n_head, 0);
    summarize();
  end
endmodule
